// [src/spb_pkg.sv]
package spb_pkg;
    localparam int SPB_PINS = 6;
    localparam int SPB_REG_W = 8;
    localparam int SPB_IN_ONLY_IDX = 3;
    localparam int SPB_TMR_CLK_IDX = 2;
    localparam logic [5:0] SPB_DIR_RST = 6'h3f;
    localparam logic [5:0] SPB_LATCH_RST = 6'h00;
    localparam logic [5:0] SPB_WAKE_PINS = 6'h0b;
    // Option register field positions
    localparam int SPB_OPT_WAKE_DIS = 7;
    localparam int SPB_OPT_PU_DIS = 6;
    localparam int SPB_OPT_TCS = 5;
    // Status register field position
    localparam int SPB_STAT_WAKE = 7;
    typedef enum {SPB_RUN, SPB_SLEEP} spb_pwr_t;
endpackage : spb_pkg

// [src/spb_pin_cell.sv]
`timescale 1ns/1ps
module spb_pin_cell (
    input wire logic dir_in,
    input wire logic latch_in,
    input wire logic no_drive_in,
    input wire logic pad_in,
    input wire logic alt_in,
    output logic pad_out,
    output logic pad_oe_out,
    output logic rd_out
);
    // One driver: bit one floats the pin, bit zero drives the latch
    assign pad_oe_out = ~dir_in & ~no_drive_in; // RULE10
    assign pad_out = latch_in;
    // Pin level, not latch; alternate-function pins read zero
    assign rd_out = alt_in ? 1'b0 : pad_in; // RULE1
endmodule : spb_pin_cell

// [src/spb_port.sv]
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: port read returns live pin levels
// RULE2: eight bits, upper two read zero
// RULE3: reset sets mask; mask write-only
// RULE4: pin three is input only
// RULE5: other pins have own direction bit
// RULE6: alternate-function pins read as zero
// RULE7: pins 0,1,3 shared pull-up and wake
// RULE8: reset-pin mode forces pull-up, no wake
// RULE9: direction load copies accumulator to mask
// RULE10: mask one floats, zero drives latch
// RULE11: timer clock select forces pin input
// RULE12: latches hold; inputs not latched
// RULE13: port write updates six latches only
// RULE14: pin change in sleep wakes, sets flag
module spb_port (
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    input wire logic [spb_pkg::SPB_REG_W-1:0] ACC_IN,
    input wire logic DIR_LOAD_IN,
    input wire logic PORT_WR_IN,
    input wire logic [spb_pkg::SPB_REG_W-1:0] PORT_WDATA_IN,
    input wire logic [spb_pkg::SPB_REG_W-1:0] OPTION_IN,
    input wire logic EXT_RESET_PIN_ENABLE_IN,
    input wire logic [spb_pkg::SPB_PINS-1:0] ALT_FUNC_IN,
    input wire logic SLEEP_IN,
    input wire logic WAKE_FLAG_CLR_IN,
    input wire logic [spb_pkg::SPB_PINS-1:0] PAD_IN,
    output logic [spb_pkg::SPB_PINS-1:0] PAD_OUT,
    output logic [spb_pkg::SPB_PINS-1:0] PAD_OE_OUT,
    output logic [spb_pkg::SPB_PINS-1:0] PULLUP_EN_OUT,
    output logic [spb_pkg::SPB_REG_W-1:0] PORT_RDATA_OUT,
    output logic WAKE_FLAG_OUT,
    output logic WAKE_OUT
);
    import spb_pkg::*;

    logic [5:0] dir_r;
    logic [5:0] latch_r;
    logic [5:0] pin_prev_r;
    logic wake_flag_r;
    spb_pwr_t pwr_r;
    spb_pwr_t pwr_nxt;
    logic [5:0] no_drive;
    logic [5:0] rd_bits;
    logic [5:0] wake_mon;
    wire pu_on = ~OPTION_IN[SPB_OPT_PU_DIS];
    wire wake_on = ~OPTION_IN[SPB_OPT_WAKE_DIS];
    wire change_hit;

    // Input-only pin never drives; timer clock select claims its pin
    always_comb begin
        no_drive = '0;
        no_drive[SPB_IN_ONLY_IDX] = 1'b1; // RULE4
        no_drive[SPB_TMR_CLK_IDX] = OPTION_IN[SPB_OPT_TCS]; // RULE11
    end

    genvar g;
    generate
        for (g = 0; g < SPB_PINS; g++) begin : g_pin
            spb_pin_cell u_cell (
                .dir_in(dir_r[g]), // RULE5
                .latch_in(latch_r[g]),
                .no_drive_in(no_drive[g]),
                .pad_in(PAD_IN[g]),
                .alt_in(ALT_FUNC_IN[g]), // RULE6
                .pad_out(PAD_OUT[g]),
                .pad_oe_out(PAD_OE_OUT[g]),
                .rd_out(rd_bits[g])
            );
        end
    endgenerate

    // Read path is combinational from pads: nothing samples the inputs
    assign PORT_RDATA_OUT = {2'b00, rd_bits}; // RULE2 RULE12

    // Pins 0,1,3 share one enable; reset-pin mode overrides pin three
    function automatic logic [5:0] spb_group_mask(
        input logic enable,
        input logic rst_pin_mode,
        input logic pin3_val
    );
        logic [5:0] mask;
        mask = enable ? SPB_WAKE_PINS : 6'h00;
        if (rst_pin_mode) begin
            mask[SPB_IN_ONLY_IDX] = pin3_val;
        end
        return mask;
    endfunction : spb_group_mask

    // Reset pin keeps its pull-up even with pull-ups globally off
    assign PULLUP_EN_OUT = spb_group_mask(pu_on, EXT_RESET_PIN_ENABLE_IN, 1'b1); // RULE7 RULE8
    // A reset pin must not wake the core through the change logic
    assign wake_mon = spb_group_mask(wake_on, EXT_RESET_PIN_ENABLE_IN, 1'b0); // RULE7 RULE8

    assign change_hit = (pwr_r == SPB_SLEEP) && |((PAD_IN ^ pin_prev_r) & wake_mon); // RULE14

    always_comb begin
        case (pwr_r)
            SPB_RUN: pwr_nxt = SLEEP_IN ? SPB_SLEEP : SPB_RUN;
            SPB_SLEEP: pwr_nxt = change_hit ? SPB_RUN : SPB_SLEEP;
            default: pwr_nxt = SPB_RUN;
        endcase
    end

    assign WAKE_OUT = change_hit; // RULE14
    assign WAKE_FLAG_OUT = wake_flag_r;

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            dir_r <= SPB_DIR_RST; // RULE3
        end else if (DIR_LOAD_IN) begin
            dir_r <= ACC_IN[5:0]; // RULE9
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            latch_r <= SPB_LATCH_RST;
        end else if (PORT_WR_IN) begin
            latch_r <= PORT_WDATA_IN[5:0]; // RULE13 RULE12
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            pwr_r <= SPB_RUN;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // Tracked while awake too, so sleep entry never sees a stale level
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            pin_prev_r <= 6'h00;
        end else begin
            pin_prev_r <= PAD_IN;
        end
    end

    // Set beats clear so a wake is never lost
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            wake_flag_r <= 1'b0;
        end else if (change_hit) begin
            wake_flag_r <= 1'b1; // RULE14
        end else if (WAKE_FLAG_CLR_IN) begin
            wake_flag_r <= 1'b0;
        end
    end

    AST_RST_INPUTS: assert property (@(posedge CLK_SYS_IN) // RULE3
        SYS_RST_IN |=> PAD_OE_OUT == 6'h00)
        else $error("pins drive after reset");
    AST_IN_ONLY: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE4
        !PAD_OE_OUT[3])
        else $error("input-only pin driven");
    AST_LOAD: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE9
        DIR_LOAD_IN |=> (PAD_OE_OUT & 6'h33) == (~$past(ACC_IN[5:0]) & 6'h33))
        else $error("direction load lost");
    AST_DRIVE: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE10
        DIR_LOAD_IN && ACC_IN[0] == 1'b0 ##1 !DIR_LOAD_IN |-> PAD_OE_OUT[0])
        else $error("cleared mask bit not driving");
    AST_TCS: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE11
        OPTION_IN[5] |-> !PAD_OE_OUT[2])
        else $error("timer clock pin driven");
    AST_UPPER: assert property (@(posedge CLK_SYS_IN) // RULE2
        PORT_RDATA_OUT[7:6] == 2'b00)
        else $error("upper bits nonzero");
    AST_ALT: assert property (@(posedge CLK_SYS_IN) // RULE6
        (PORT_RDATA_OUT[5:0] & ALT_FUNC_IN) == 6'h00)
        else $error("alternate pin reads nonzero");
    AST_READ: assert property (@(posedge CLK_SYS_IN) // RULE1
        PORT_RDATA_OUT[5:0] == (PAD_IN & ~ALT_FUNC_IN))
        else $error("read not pin level");
    AST_LATCH: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE13
        PORT_WR_IN ##1 !PORT_WR_IN [*2] |-> PAD_OUT == $past(PORT_WDATA_IN[5:0], 2))
        else $error("latch not held");
    AST_PU: assert property (@(posedge CLK_SYS_IN) // RULE8
        EXT_RESET_PIN_ENABLE_IN |-> PULLUP_EN_OUT[3])
        else $error("reset pin pull-up off");
    AST_PU_NONE: assert property (@(posedge CLK_SYS_IN) // RULE7
        (PULLUP_EN_OUT & 6'h34) == 6'h00)
        else $error("pull-up on unsupported pin");
    AST_WAKE: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE14
        WAKE_OUT |=> WAKE_FLAG_OUT && pwr_r == SPB_RUN)
        else $error("wake did not set flag");

    // Wake logic: only monitored pins, never while disabled
    AST_NO_WAKE: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE7
        ((PAD_IN ^ $past(PAD_IN)) & SPB_WAKE_PINS) == 6'h00 |-> !WAKE_OUT)
        else $error("wake without monitored change");
    AST_RST_PIN_WAKE: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE8
        EXT_RESET_PIN_ENABLE_IN && ((PAD_IN ^ $past(PAD_IN)) & 6'h03) == 6'h00 |-> !WAKE_OUT)
        else $error("reset pin woke core");
    AST_WAKE_OFF: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE7
        OPTION_IN[SPB_OPT_WAKE_DIS] |-> !WAKE_OUT)
        else $error("wake while disabled");

    // Latches and mask change only on their own strobes
    AST_HOLD: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE12
        !PORT_WR_IN |=> $stable(PAD_OUT))
        else $error("latch changed without write");
    AST_MASK_HOLD: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE9
        !DIR_LOAD_IN |=> $stable(PAD_OE_OUT & 6'h3b))
        else $error("drive changed without load");
    AST_PIN2_DRIVE: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE5
        DIR_LOAD_IN && !ACC_IN[2] ##1 !DIR_LOAD_IN && !OPTION_IN[5] |-> PAD_OE_OUT[2])
        else $error("cleared mask bit on pin two not driving");

    // Flag clears only when no wake lands in the same cycle
    AST_FLAG_CLR: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) // RULE14
        WAKE_FLAG_CLR_IN && !WAKE_OUT |=> !WAKE_FLAG_OUT)
        else $error("flag not cleared");
    AST_RST_STATE: assert property (@(posedge CLK_SYS_IN) // RULE14
        SYS_RST_IN |=> !WAKE_FLAG_OUT && !WAKE_OUT)
        else $error("wake state survives reset");

    COV_WAKE: cover property (@(posedge CLK_SYS_IN) WAKE_OUT);
    COV_LOAD: cover property (@(posedge CLK_SYS_IN) DIR_LOAD_IN ##1 PORT_WR_IN);
    COV_DRIVE: cover property (@(posedge CLK_SYS_IN) |PAD_OE_OUT);
    COV_SET_CLR: cover property (@(posedge CLK_SYS_IN) WAKE_OUT && WAKE_FLAG_CLR_IN);
    COV_RST_PIN: cover property (@(posedge CLK_SYS_IN)
        EXT_RESET_PIN_ENABLE_IN && pwr_r == SPB_SLEEP);
endmodule : spb_port

// [test/spb_ext_model.sv]
`timescale 1ns/1ps
module spb_ext_model (
    input wire logic [5:0] pad_out_in,
    input wire logic [5:0] pad_oe_in,
    input wire logic [5:0] pullup_en_in,
    input wire logic [5:0] ext_val_in,
    input wire logic [5:0] ext_en_in,
    output logic [5:0] level_out
);
    // A floating pin shows the inverse, so a stale value never passes
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pad_oe_in[i]) level_out[i] = pad_out_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else if (pullup_en_in[i]) level_out[i] = 1'b1;
            else level_out[i] = ~ext_val_in[i];
        end
    end
endmodule : spb_ext_model

// [test/tb_six_pin_bidir_port.sv]
`timescale 1ns/1ps
module tb_six_pin_bidir_port;
    import spb_pkg::*;
    logic clk = 0, rst = 1, dl = 0, wr = 0, mre = 0, slp = 0, fclr = 0, wf, wk;
    logic [7:0] acc = 0, wd = 0, opt = 8'hc0, rd;
    logic [5:0] alt = 0, ev = 0, ee = 0, lvl, po, oe, pu, m_e = 6'h3f, l_e = 0;
    logic [31:0] seed = 32'hce81;
    int miscompares = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    spb_port DUT (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .ACC_IN(acc), .DIR_LOAD_IN(dl),
        .PORT_WR_IN(wr), .PORT_WDATA_IN(wd), .OPTION_IN(opt),
        .EXT_RESET_PIN_ENABLE_IN(mre), .ALT_FUNC_IN(alt), .SLEEP_IN(slp),
        .WAKE_FLAG_CLR_IN(fclr), .PAD_IN(lvl), .PAD_OUT(po), .PAD_OE_OUT(oe),
        .PULLUP_EN_OUT(pu), .PORT_RDATA_OUT(rd), .WAKE_FLAG_OUT(wf), .WAKE_OUT(wk));
    spb_ext_model ext (.pad_out_in(po), .pad_oe_in(oe), .pullup_en_in(pu),
        .ext_val_in(ev), .ext_en_in(ee), .level_out(lvl));
    function automatic logic [31:0] lf(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lf
    function automatic logic [5:0] exp_oe();
        return ~m_e & 6'h37 & ~(opt[5] ? 6'h04 : 6'h00);
    endfunction : exp_oe
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("Error %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask : chk
    task automatic check_all();
        logic [5:0] eoe, epu, elv;
        eoe = exp_oe();
        epu = (opt[6] ? 6'h00 : SPB_WAKE_PINS) | (mre ? 6'h08 : 6'h00);
        for (int i = 0; i < 6; i++) begin
            elv[i] = eoe[i] ? l_e[i] : ee[i] ? ev[i] : epu[i] ? 1'b1 : ~ev[i];
        end
        chk({2'b00, oe}, {2'b00, eoe}, "drive enable");
        chk({2'b00, po}, {2'b00, l_e}, "latch");
        chk({2'b00, pu}, {2'b00, epu}, "pull-up");
        chk(rd, {2'b00, elv & ~alt}, "read");
    endtask : check_all
    task stop_test;
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        #1 check_all();
        $display("Test reset done");
        for (int n = 0; n < 60; n++) begin
            seed = lf(seed);
            acc = (n == 0) ? 8'hc0 : seed[7:0];
            wd = seed[15:8];
            dl = seed[16] | (n == 0);
            wr = seed[17];
            opt = {1'b1, seed[19:18], 5'h00};
            mre = seed[20];
            alt = seed[26:21];
            @(posedge clk);
            if (dl) m_e = acc[5:0];
            if (wr) l_e = wd[5:0];
            @(negedge clk);
            {dl, wr} = 2'b00;
            seed = lf(seed);
            ev = seed[5:0];
            ee = seed[11:6] & ~exp_oe();
            #1 check_all();
        end
        $display("Test random done");
        {opt, mre, alt, acc, ev, ee, dl} = {8'h00, 1'b1, 6'h00, 8'hff, 6'h00, 6'h3f, 1'b1};
        @(negedge clk);
        {m_e, dl, slp} = {6'h3f, 2'b01};
        @(negedge clk);
        slp = 0;
        ev[5:2] = 4'hf;
        #1 chk({7'h00, wk}, 8'h00, "unmonitored pin wake");
        @(negedge clk);
        ev[0] = 1'b1;
        #1 chk({7'h00, wk}, 8'h01, "wake pulse");
        @(negedge clk);
        chk({7'h00, wf}, 8'h01, "wake flag");
        fclr = 1;
        @(negedge clk);
        fclr = 0;
        chk({7'h00, wf}, 8'h00, "flag clear");
        // Sleep again; a wake and a clear in one cycle, set must win
        slp = 1;
        @(negedge clk);
        {slp, fclr} = 2'b01;
        ev[1] = 1'b1;
        #1 chk({7'h00, wk}, 8'h01, "wake beside clear");
        @(negedge clk);
        fclr = 0;
        chk({7'h00, wf}, 8'h01, "set beats clear");
        {opt, slp} = {8'h80, 1'b1};
        @(negedge clk);
        slp = 0;
        ev[0] = 1'b0;
        #1 chk({7'h00, wk}, 8'h00, "wake disabled");
        $display("Test wake done");
        {acc, wd, dl, wr} = {8'h00, 8'hff, 2'b11};
        @(negedge clk);
        {dl, wr, rst, m_e, l_e} = {3'b001, 6'h00, 6'h3f};
        #1 check_all();
        @(negedge clk);
        {rst, m_e, l_e} = {1'b0, 6'h3f, 6'h00};
        #1 check_all();
        chk({7'h00, wf}, 8'h00, "flag after reset");
        $display("Test mid-run reset done");
        stop_test();
    end
endmodule : tb_six_pin_bidir_port
